/* File: verilog/hip_map.svh */
// Purpose: Register offsets, field positions, reset values and sizes of the interrupt prioritizer
// Assumes: 32-bit AXI4-Lite register port with 12-bit byte addresses
// Notes: Definitions only
`ifndef HIP_MAP_SVH
`define HIP_MAP_SVH

`define HIP_NUM_EVT 64
`define HIP_NUM_CH 10
`define HIP_NUM_HOST 10
`define HIP_NEST_NONE 4'ha
`define HIP_NONE_BIT 31
`define HIP_RESP_OKAY 2'h0
`define HIP_RESP_SLVERR 2'h2

`define HIP_OFF_GLOBAL_EN 12'h000
`define HIP_OFF_NEST_MODE 12'h004
`define HIP_OFF_GLOBAL_NEST 12'h008
`define HIP_OFF_GLOBAL_WIN 12'h00c
`define HIP_OFF_IDX_STAT_CLR 12'h010
`define HIP_OFF_IDX_EN_SET 12'h014
`define HIP_OFF_IDX_EN_CLR 12'h018
`define HIP_OFF_IDX_HOST_SET 12'h01c
`define HIP_OFF_IDX_HOST_CLR 12'h020
`define HIP_OFF_HOST_EN 12'h024
`define HIP_OFF_NEST_DONE 12'h028
`define HIP_OFF_AWAKE 12'h02c
`define HIP_OFF_STAT_CLR0 12'h030
`define HIP_OFF_STAT_CLR1 12'h034
`define HIP_OFF_RAW0 12'h038
`define HIP_OFF_RAW1 12'h03c
`define HIP_OFF_EN0 12'h040
`define HIP_OFF_EN1 12'h044
`define HIP_OFF_EN_CLR0 12'h048
`define HIP_OFF_EN_CLR1 12'h04c
`define HIP_OFF_POL0 12'h050
`define HIP_OFF_POL1 12'h054
`define HIP_OFF_TYPE0 12'h058
`define HIP_OFF_TYPE1 12'h05c
// Three channel-to-host words at 0x060..0x068, one byte per channel
`define HIP_HMAP_BLK 8'h06
// Sixteen event-to-channel words at 0x080..0x0bc, one byte per event
`define HIP_CMAP_BLK 6'h02
// Per-host winner index words at 0x100 + 4*h
`define HIP_HWIN_BLK 6'h04
// Per-host nest level words at 0x140 + 4*h
`define HIP_HNEST_BLK 6'h05

`define HIP_POL_VALUE 32'hffff_ffff
`define HIP_TYPE_VALUE 32'h0000_0000

`endif

/* File: verilog/hip_pkg.sv */
// Purpose: Types shared by the interrupt prioritizer modules
// Assumes: Nothing beyond the register map header
// Notes: Nest mode is kept one-hot
package hip_pkg;

  typedef enum logic [2:0] {
    HIP_NEST_OFF = 3'b001,
    HIP_NEST_GLOBAL = 3'b010,
    HIP_NEST_HOST = 3'b100
  } hip_nest_e;

  // Candidate of a priority search: a channel and its best pending event
  typedef struct packed {
    logic act;
    logic [3:0] chan;
    logic [5:0] evt;
  } hip_win_s;

endpackage : hip_pkg

/* File: verilog/hip_chan_pick.sv */
// Purpose: Lowest-index enabled pending event among those mapped to one channel
// Assumes: Event map is flattened, four bits per event
// Notes: Purely combinational
module hip_chan_pick import hip_pkg::*; #(
  parameter logic [3:0] CH = 4'h0
) (
  input wire logic [63:0] pend_en,
  input wire logic [255:0] ev_chan,
  output hip_win_s win
);

  // Descending scan so the lowest matching index is assigned last
  always_comb begin
    win = '0;
    win.chan = CH;
    for (int i = 63; i >= 0; i--) begin
      if (pend_en[i] && ev_chan[4*i +: 4] == CH) begin
        win.act = 1'b1;
        win.evt = 6'(i);
      end
    end
  end

endmodule : hip_chan_pick

/* File: verilog/hip_top.sv */
// Purpose: Channel and host priority resolution, nesting and status for 64 pulse events
// Assumes: Events arrive as active-high single-cycle pulses synchronous to aclk
// Notes: Registers reached over AXI4-Lite; one write and one read at a time
`include "hip_map.svh"

module hip_top import hip_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [63:0] evt_pulse,
  output logic [9:0] host_irq,
  output logic core_awake,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  function automatic logic [31:0] win_word(input hip_win_s w);
    win_word = w.act ? {26'h000_0000, w.evt} : (32'h0000_0001 << `HIP_NONE_BIT);
  endfunction : win_word

  // Bus handshake state
  logic aw_got_q, w_got_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [11:0] waddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  // Controller state
  logic [63:0] raw_q, en_q;
  logic [3:0] ev_chan_q [64];
  logic [3:0] ch_host_q [10];
  logic [9:0] host_en_q, host_irq_q;
  logic gen_en_q, awake_q;
  hip_nest_e mode_q;
  logic [3:0] gnest_q, gsave_q;
  logic [3:0] hnest_q [10];
  logic [3:0] hsave_q [10];
  hip_win_s host_win_q [10];
  hip_win_s glob_win_q;

  // Write and read channel handshakes
  wire aw_hs = s_axi_awvalid && awready_q;
  wire w_hs = s_axi_wvalid && wready_q;
  wire do_wr = aw_got_q && w_got_q && !bvalid_q;
  wire aw_got_d = (aw_got_q || aw_hs) && !do_wr;
  wire w_got_d = (w_got_q || w_hs) && !do_wr;
  wire bvalid_d = do_wr || (bvalid_q && !s_axi_bready);
  wire ar_hs = s_axi_arvalid && arready_q;
  wire rvalid_d = ar_hs || (rvalid_q && !s_axi_rready);

  // Write decode
  wire [5:0] widx6 = wdata_q[5:0];
  wire [3:0] widx4 = wdata_q[3:0];
  wire wr_gen = do_wr && waddr_q == `HIP_OFF_GLOBAL_EN;
  wire wr_mode = do_wr && waddr_q == `HIP_OFF_NEST_MODE;
  wire wr_gnest = do_wr && waddr_q == `HIP_OFF_GLOBAL_NEST;
  wire wr_idx_sclr = do_wr && waddr_q == `HIP_OFF_IDX_STAT_CLR;
  wire wr_idx_eset = do_wr && waddr_q == `HIP_OFF_IDX_EN_SET;
  wire wr_idx_eclr = do_wr && waddr_q == `HIP_OFF_IDX_EN_CLR;
  wire wr_hset = do_wr && waddr_q == `HIP_OFF_IDX_HOST_SET && widx4 < 4'ha;
  wire wr_hclr = do_wr && waddr_q == `HIP_OFF_IDX_HOST_CLR && widx4 < 4'ha;
  wire wr_hen = do_wr && waddr_q == `HIP_OFF_HOST_EN;
  wire wr_done = do_wr && waddr_q == `HIP_OFF_NEST_DONE && widx4 < 4'ha;
  wire wr_sc0 = do_wr && waddr_q == `HIP_OFF_STAT_CLR0;
  wire wr_sc1 = do_wr && waddr_q == `HIP_OFF_STAT_CLR1;
  wire wr_ec0 = do_wr && waddr_q == `HIP_OFF_EN_CLR0;
  wire wr_ec1 = do_wr && waddr_q == `HIP_OFF_EN_CLR1;
  wire wr_cmap = do_wr && waddr_q[11:6] == `HIP_CMAP_BLK;
  wire wr_hmap = do_wr && waddr_q[11:4] == `HIP_HMAP_BLK && waddr_q[3:2] != 2'h3;
  wire wr_hnest = do_wr && waddr_q[11:6] == `HIP_HNEST_BLK && waddr_q[5:2] < 4'ha;
  wire [63:0] stat_clr = (wr_sc0 ? {32'h0000_0000, wdata_q} : 64'h0000_0000_0000_0000)
    | (wr_sc1 ? {wdata_q, 32'h0000_0000} : 64'h0000_0000_0000_0000)
    | (wr_idx_sclr ? (64'h0000_0000_0000_0001 << widx6) : 64'h0000_0000_0000_0000);
  wire [63:0] en_clr = (wr_ec0 ? {32'h0000_0000, wdata_q} : 64'h0000_0000_0000_0000)
    | (wr_ec1 ? {wdata_q, 32'h0000_0000} : 64'h0000_0000_0000_0000)
    | (wr_idx_eclr ? (64'h0000_0000_0000_0001 << widx6) : 64'h0000_0000_0000_0000);
  wire [63:0] en_set = wr_idx_eset ? (64'h0000_0000_0000_0001 << widx6) : 64'h0000_0000_0000_0000;
  wire [63:0] raw_d = (raw_q & ~stat_clr) | evt_pulse;
  wire [63:0] en_d = (en_q & ~en_clr) | en_set;
  wire [63:0] pend_en = raw_q & en_q;
  wire [9:0] hen_set = wr_hset ? 10'(10'h001 << widx4) : 10'h000;
  wire [9:0] hen_clr = wr_hclr ? 10'(10'h001 << widx4) : 10'h000;
  wire [9:0] host_en_d = wr_hen ? wdata_q[9:0] : ((host_en_q & ~hen_clr) | hen_set);
  wire [3:0] wr_cmap_row = waddr_q[5:2];
  wire [1:0] wr_hmap_row = waddr_q[3:2];

  // Read decode and taking an interrupt
  wire [3:0] rd_row = s_axi_araddr[5:2];
  wire rd_hwin = s_axi_araddr[11:6] == `HIP_HWIN_BLK && rd_row < 4'ha;
  wire take = ar_hs && rd_hwin && host_win_q[rd_row].act;
  wire take_g = take && mode_q == HIP_NEST_GLOBAL;
  wire take_h = take && mode_q == HIP_NEST_HOST;
  wire done_g = wr_done && mode_q == HIP_NEST_GLOBAL;
  wire done_h = wr_done && mode_q == HIP_NEST_HOST;
  wire [3:0] take_chan = host_win_q[rd_row].chan;

  // Priority search
  logic [255:0] ev_chan_flat;
  hip_win_s chan_win [10];
  hip_win_s host_win [10];
  hip_win_s glob_win;
  logic [9:0] host_irq_d;

  genvar g;
  generate
    for (g = 0; g < `HIP_NUM_EVT; g++) begin : g_evt
      assign ev_chan_flat[4*g +: 4] = ev_chan_q[g];
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ev_chan_q[g] <= 4'h0;
        end else if (wr_cmap && wr_cmap_row == 4'(g / 4) && wstrb_q[g % 4]) begin
          ev_chan_q[g] <= wdata_q[8*(g % 4) +: 4];
        end
      end
    end

    for (g = 0; g < `HIP_NUM_CH; g++) begin : g_ch
      hip_chan_pick #(.CH(4'(g))) u_pick (
        .pend_en(pend_en),
        .ev_chan(ev_chan_flat),
        .win(chan_win[g])
      );
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ch_host_q[g] <= 4'(g);
        end else if (wr_hmap && wr_hmap_row == 2'(g / 4) && wstrb_q[g % 4]) begin
          ch_host_q[g] <= wdata_q[8*(g % 4) +: 4];
        end
      end
    end

    for (g = 0; g < `HIP_NUM_HOST; g++) begin : g_host
      logic [3:0] lvl;
      assign lvl = (mode_q == HIP_NEST_GLOBAL) ? gnest_q :
                   (mode_q == HIP_NEST_HOST) ? hnest_q[g] : `HIP_NEST_NONE;
      always_comb begin
        host_win[g] = '0;
        for (int c = `HIP_NUM_CH - 1; c >= 0; c--) begin
          if (chan_win[c].act && ch_host_q[c] == 4'(g) && 4'(c) < lvl) begin
            host_win[g] = chan_win[c];
          end
        end
      end
      // A set through the indexed host enable re-triggers by dropping the line one cycle
      assign host_irq_d[g] = gen_en_q && host_en_q[g] && host_win[g].act
        && !(hen_set[g] && host_en_q[g]);
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          hnest_q[g] <= `HIP_NEST_NONE;
          hsave_q[g] <= `HIP_NEST_NONE;
        end else if (wr_hnest && waddr_q[5:2] == 4'(g)) begin
          hnest_q[g] <= wdata_q[3:0];
        end else if (take_h && rd_row == 4'(g)) begin
          hsave_q[g] <= hnest_q[g];
          hnest_q[g] <= take_chan;
        end else if (done_h && widx4 == 4'(g)) begin
          hnest_q[g] <= hsave_q[g];
        end
      end
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          host_win_q[g] <= '0;
        end else begin
          host_win_q[g] <= host_win[g];
        end
      end
    end
  endgenerate

  // Global winner: lowest active channel that global nesting lets through
  always_comb begin
    glob_win = '0;
    for (int c = `HIP_NUM_CH - 1; c >= 0; c--) begin
      if (chan_win[c].act && (mode_q != HIP_NEST_GLOBAL || 4'(c) < gnest_q)) begin
        glob_win = chan_win[c];
      end
    end
  end

  // Read mux
  logic [31:0] rd_word;
  logic rd_err;
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err = 1'b0;
    if (s_axi_araddr[11:6] == `HIP_CMAP_BLK) begin
      for (int k = 0; k < 4; k++) begin
        rd_word[8*k +: 4] = ev_chan_q[4*rd_row + k];
      end
    end else if (s_axi_araddr[11:4] == `HIP_HMAP_BLK && s_axi_araddr[3:2] != 2'h3) begin
      for (int k = 0; k < 4; k++) begin
        if (4*s_axi_araddr[3:2] + k < `HIP_NUM_CH) begin
          rd_word[8*k +: 4] = ch_host_q[4*s_axi_araddr[3:2] + k];
        end
      end
    end else if (rd_hwin) begin
      rd_word = win_word(host_win_q[rd_row]);
    end else if (s_axi_araddr[11:6] == `HIP_HNEST_BLK && rd_row < 4'ha) begin
      rd_word = {28'h000_0000, hnest_q[rd_row]};
    end else begin
      unique case (s_axi_araddr)
        `HIP_OFF_GLOBAL_EN: rd_word = {31'h0000_0000, gen_en_q};
        `HIP_OFF_NEST_MODE: rd_word = {30'h0000_0000, mode_q[2], mode_q[1]};
        `HIP_OFF_GLOBAL_NEST: rd_word = {28'h000_0000, gnest_q};
        `HIP_OFF_GLOBAL_WIN: rd_word = win_word(glob_win_q);
        `HIP_OFF_HOST_EN: rd_word = {22'h00_0000, host_en_q};
        `HIP_OFF_AWAKE: rd_word = {31'h0000_0000, awake_q};
        `HIP_OFF_STAT_CLR0: rd_word = pend_en[31:0];
        `HIP_OFF_STAT_CLR1: rd_word = pend_en[63:32];
        `HIP_OFF_RAW0: rd_word = raw_q[31:0];
        `HIP_OFF_RAW1: rd_word = raw_q[63:32];
        `HIP_OFF_EN0, `HIP_OFF_EN_CLR0: rd_word = en_q[31:0];
        `HIP_OFF_EN1, `HIP_OFF_EN_CLR1: rd_word = en_q[63:32];
        `HIP_OFF_POL0, `HIP_OFF_POL1: rd_word = `HIP_POL_VALUE;
        `HIP_OFF_TYPE0, `HIP_OFF_TYPE1: rd_word = `HIP_TYPE_VALUE;
        `HIP_OFF_IDX_STAT_CLR, `HIP_OFF_IDX_EN_SET, `HIP_OFF_IDX_EN_CLR,
        `HIP_OFF_IDX_HOST_SET, `HIP_OFF_IDX_HOST_CLR, `HIP_OFF_NEST_DONE: rd_word = 32'h0000_0000;
        default: rd_err = 1'b1;
      endcase
    end
  end

  // Write-address decode for the response code
  wire wr_known = wr_gen || wr_mode || wr_gnest || wr_idx_sclr || wr_idx_eset || wr_idx_eclr
    || (do_wr && waddr_q == `HIP_OFF_IDX_HOST_SET) || (do_wr && waddr_q == `HIP_OFF_IDX_HOST_CLR)
    || wr_hen || (do_wr && waddr_q == `HIP_OFF_NEST_DONE) || wr_sc0 || wr_sc1 || wr_ec0 || wr_ec1
    || wr_cmap || wr_hmap || wr_hnest
    || (do_wr && waddr_q[11:4] == 8'h05) || (do_wr && waddr_q == `HIP_OFF_GLOBAL_WIN)
    || (do_wr && waddr_q[11:3] == 9'h007) || (do_wr && waddr_q == `HIP_OFF_AWAKE)
    || (do_wr && waddr_q[11:3] == 9'h008)
    || (do_wr && waddr_q[11:6] == `HIP_HWIN_BLK && waddr_q[5:2] < 4'ha);
  wire hip_nest_mode_wr_g = wdata_q[1:0] == 2'h1;
  wire hip_nest_mode_wr_h = wdata_q[1:0] == 2'h2;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `HIP_RESP_OKAY;
      waddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awready_q <= !aw_got_d && !bvalid_d;
      wready_q <= !w_got_d && !bvalid_d;
      bvalid_q <= bvalid_d;
      if (do_wr) begin
        bresp_q <= wr_known ? `HIP_RESP_OKAY : `HIP_RESP_SLVERR;
      end
      if (aw_hs) begin
        waddr_q <= {s_axi_awaddr[11:2], 2'h0};
      end
      if (w_hs) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `HIP_RESP_OKAY;
    end else begin
      arready_q <= !rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_hs) begin
        rdata_q <= rd_err ? 32'h0000_0000 : rd_word;
        rresp_q <= rd_err ? `HIP_RESP_SLVERR : `HIP_RESP_OKAY;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw_q <= 64'h0000_0000_0000_0000;
      en_q <= 64'h0000_0000_0000_0000;
      host_en_q <= 10'h000;
      gen_en_q <= 1'b0;
      mode_q <= HIP_NEST_OFF;
      glob_win_q <= '0;
      host_irq_q <= 10'h000;
      awake_q <= 1'b0;
    end else begin
      raw_q <= raw_d;
      en_q <= en_d;
      host_en_q <= host_en_d;
      if (wr_gen) begin
        gen_en_q <= wdata_q[0];
      end
      if (wr_mode) begin
        mode_q <= hip_nest_mode_wr_g ? HIP_NEST_GLOBAL :
                  hip_nest_mode_wr_h ? HIP_NEST_HOST : HIP_NEST_OFF;
      end
      glob_win_q <= glob_win;
      host_irq_q <= host_irq_d;
      awake_q <= |raw_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gnest_q <= `HIP_NEST_NONE;
      gsave_q <= `HIP_NEST_NONE;
    end else if (wr_gnest) begin
      gnest_q <= wdata_q[3:0];
    end else if (take_g) begin
      gsave_q <= gnest_q;
      gnest_q <= take_chan;
    end else if (done_g) begin
      gnest_q <= gsave_q;
    end
  end

  assign host_irq = host_irq_q;
  assign core_awake = awake_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule : hip_top

/* File: verification/hip_top_chk.sv */
// Purpose: Port-level checks of the prioritizer register bus and wake output
// Assumes: Single clock domain, synchronous active-low reset
// Notes: Attached by bind from the testbench file
module hip_top_chk import hip_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [63:0] evt_pulse,
  input wire logic core_awake,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  awake_after_event_a: assert property ((|evt_pulse) |-> ##2 core_awake)
    else $error("core stayed asleep after an event");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before accept");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped before accept");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  write_time_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response at wrong cycle");
  read_time_a: assert property (s_axi_arvalid && s_axi_arready |=> $rose(s_axi_rvalid))
    else $error("read data at wrong cycle");
  read_hole_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[11:9] != 3'h0
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  write_hole_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready && s_axi_awaddr[11:9] != 3'h0 |-> ##2 s_axi_bresp == 2'h2)
    else $error("unmapped write not refused");
endmodule : hip_top_chk

/* File: verification/hip_evt_src.sv */
// Purpose: Event source standing in for the peripherals and cores
// Assumes: Fire request is driven just after a rising edge
// Notes: Emits one-cycle active-high pulses only
module hip_evt_src (
  input wire logic aclk,
  input wire logic fire,
  input wire logic [5:0] idx,
  output logic [63:0] evt_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  initial evt_pulse = 64'h0000_0000_0000_0000;
  // One-cycle pulse on the requested event, quiet otherwise
  always @(posedge aclk) begin
    evt_pulse <= fire ? (64'h0000_0000_0000_0001 << idx) : 64'h0000_0000_0000_0000;
  end
endmodule : hip_evt_src

/* File: verification/tb.sv */
// Purpose: Register-level tests of priority, nesting, clearing and wake
// Assumes: Register map and bus timing of the prioritizer
// Notes: Events come from the event source model
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic fire = 1'b0;
  logic [5:0] idx = 6'h00;
  logic [63:0] evt_pulse;
  logic [9:0] host_irq;
  logic core_awake;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int n_mismatch = 0;
  int comparisons = 0;

  hip_top hip_top_i (.aclk, .aresetn, .evt_pulse, .host_irq, .core_awake,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  hip_evt_src hip_evt_src_i (.aclk, .fire, .idx, .evt_pulse);

  initial begin
    forever #4 aclk = ~aclk;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, s, e);
    end
  endtask : check

  task automatic limit(input int n);
    if (n >= 64) begin
      n_mismatch++;
      $display("unexpected at %0t ns: bus wait ran out", $time);
      give_verdict();
    end
  endtask : limit

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int n;
    logic pa, pw;
    n = 0;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while ((pa || pw) && n < 64) begin
      @(posedge aclk);
      n++;
      if (pa && s_axi_awready) begin
        pa = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (pw && s_axi_wready) begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    // Accept the response late so that it must stand while pending
    repeat (2) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid && ++n < 64);
    s_axi_bready <= 1'b0;
    check({30'h0, s_axi_bresp}, {30'h0, er});
    limit(n);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready && ++n < 64);
    s_axi_arvalid <= 1'b0;
    // Accept the data one cycle late so that it must stand while pending
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid && ++n < 64);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, ed);
    check({30'h0, s_axi_rresp}, {30'h0, er});
    limit(n);
  endtask : rd

  // Pulse one event, then allow the two-cycle path to the outputs
  task automatic fire_evt(input logic [5:0] i);
    @(posedge aclk);
    fire <= 1'b1;
    idx <= i;
    @(posedge aclk);
    fire <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : fire_evt

  // Host output h, or the wake output when h is 10, polled mid-cycle
  task automatic wsig(input int h, input logic e);
    int n;
    logic s;
    n = 0;
    do begin
      @(negedge aclk);
      s = (h < 10) ? host_irq[h] : core_awake;
    end while (s !== e && ++n < 16);
    check({31'h0, s}, {31'h0, e});
  endtask : wsig

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h00c, 32'h8000_0000);
    rd(12'h140, 32'h0000_000a);
    rd(12'h050, 32'hffff_ffff);
    wr(12'h050, 32'h0000_0000);
    rd(12'h050, 32'hffff_ffff);
    rd(12'h05c, 32'h0000_0000);
    rd(12'h200, 32'h0000_0000, 2'h2);
    wr(12'h200, 32'h0000_0001, 2'h2);
    $display("test reset and fixed words done");
    wr(12'h084, 32'h0000_0300);
    wr(12'h088, 32'h0000_0300);
    wr(12'h0a8, 32'h0000_0001);
    wr(12'h060, 32'h0102_0100);
    wr(12'h014, 32'h0000_0005);
    wr(12'h014, 32'h0000_0009);
    wr(12'h014, 32'h0000_0028);
    wr(12'h01c, 32'h0000_0001);
    wr(12'h000, 32'h0000_0001);
    fire_evt(6'd9);
    fire_evt(6'd5);
    wsig(1, 1'b1);
    check({22'h00_0000, host_irq}, 32'h0000_0002);
    rd(12'h104, 32'h0000_0005);
    fire_evt(6'd40);
    rd(12'h104, 32'h0000_0028);
    rd(12'h00c, 32'h0000_0028);
    rd(12'h030, 32'h0000_0220);
    rd(12'h034, 32'h0000_0100);
    wr(12'h000, 32'h0000_0000);
    wsig(1, 1'b0);
    wr(12'h000, 32'h0000_0001);
    wsig(1, 1'b1);
    wr(12'h010, 32'h0000_0028);
    rd(12'h104, 32'h0000_0005);
    wr(12'h030, 32'h0000_0020);
    rd(12'h104, 32'h0000_0009);
    wr(12'h048, 32'h0000_0200);
    rd(12'h030, 32'h0000_0000);
    rd(12'h038, 32'h0000_0200);
    rd(12'h104, 32'h8000_0000);
    wsig(1, 1'b0);
    wr(12'h014, 32'h0000_0009);
    wr(12'h018, 32'h0000_0009);
    rd(12'h040, 32'h0000_0020);
    wsig(10, 1'b1);
    wr(12'h010, 32'h0000_0009);
    wsig(10, 1'b0);
    rd(12'h02c, 32'h0000_0000);
    $display("test priority and clearing done");
    wr(12'h004, 32'h0000_0001);
    fire_evt(6'd5);
    wsig(1, 1'b1);
    rd(12'h104, 32'h0000_0005);
    rd(12'h008, 32'h0000_0003);
    wsig(1, 1'b0);
    fire_evt(6'd40);
    wsig(1, 1'b1);
    wr(12'h010, 32'h0000_0028);
    wsig(1, 1'b0);
    wr(12'h028, 32'h0000_0001);
    rd(12'h008, 32'h0000_000a);
    wsig(1, 1'b1);
    wr(12'h008, 32'h0000_0002);
    wsig(1, 1'b0);
    rd(12'h008, 32'h0000_0002);
    wr(12'h008, 32'h0000_000a);
    wr(12'h010, 32'h0000_0005);
    $display("test global nesting done");
    wr(12'h088, 32'h0000_0200);
    wr(12'h014, 32'h0000_0009);
    wr(12'h01c, 32'h0000_0002);
    wr(12'h004, 32'h0000_0002);
    fire_evt(6'd5);
    fire_evt(6'd9);
    wsig(2, 1'b1);
    rd(12'h104, 32'h0000_0005);
    rd(12'h144, 32'h0000_0003);
    wsig(1, 1'b0);
    wsig(2, 1'b1);
    rd(12'h148, 32'h0000_000a);
    wr(12'h028, 32'h0000_0001);
    rd(12'h144, 32'h0000_000a);
    wsig(1, 1'b1);
    wr(12'h148, 32'h0000_0002);
    wsig(2, 1'b0);
    rd(12'h148, 32'h0000_0002);
    $display("test per-host nesting done");
    wr(12'h004, 32'h0000_0000);
    wsig(2, 1'b1);
    wr(12'h024, 32'h0000_0000);
    wsig(1, 1'b0);
    wr(12'h018, 32'h0000_0005);
    wr(12'h024, 32'h0000_0006);
    rd(12'h024, 32'h0000_0006);
    wsig(2, 1'b1);
    wsig(1, 1'b0);
    wr(12'h014, 32'h0000_0005);
    wsig(1, 1'b1);
    wr(12'h020, 32'h0000_0002);
    wsig(2, 1'b0);
    $display("test manual nesting done");
    give_verdict();
  end
endmodule : tb

bind hip_top hip_top_chk hip_top_chk_i (.aclk, .aresetn, .evt_pulse, .core_awake,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
